// File: hdl/mac40_top.sv
// math accelerator with 40-bit accumulator behind an AHB-Lite slave
// How it works
// - operation is picked from the order of port A, B and count accesses.
// - four A bytes then two B bytes start a 32/16 divide, 36 clocks.
// - two A bytes then two B bytes start a 16/16 divide, 24 clocks.
// - after divide, A reads give quotient MSB first, then B gives remainder.
// - two B bytes then two A bytes start a 16x16 multiply, 24 clocks.
// - after multiply, four A reads return the product MSB first.
// - four A bytes then a nonzero count start a 36-clock shift.
// - four A bytes then count zero normalize; exponent lands in count.
// - busy flag is set while running and clears on completion.
// - accesses to other registers leave the sequence state alone.
// - out-of-order A, B or accumulator access corrupts; clearing busy restarts.
// - every multiply or divide result is added into the accumulator.
// - accumulator is usable only while the accumulate flag is clear.
// - five accumulator writes load it, least significant byte first.
// - five accumulator reads return it, most significant byte first.
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/10ps
module mac40_top
	import mac40_pkg::*;
#(
	parameter int ACC_W = 40
)
(
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp
);
	localparam int ACC_BYTES = ACC_W / 8;

	if (ACC_W < 32 || ACC_W > 64 || (ACC_W % 8) != 0)
		$error("ACC_W must be a whole number of bytes from 32 to 64");
	logic             reg_wr;
	logic             reg_rd;
	logic [7:0]       reg_idx;
	logic [7:0]       reg_wdata;
	logic [7:0]       reg_rdata;
	mac40_seq_t       seq_q;
	mac40_op_t        op_q;
	logic [2:0]       a_cnt_q;
	logic [1:0]       b_cnt_q;
	logic [31:0]      opa_q;
	logic [15:0]      opb_q;
	logic [4:0]       cnt_q;
	logic             dir_q;
	logic [31:0]      res_q;
	logic [15:0]      rem_q;
	logic [2:0]       ard_q;
	logic [1:0]       brd_q;
	logic [ACC_W-1:0] acc_q;
	logic [2:0]       acc_wp_q;
	logic [2:0]       acc_rp_q;
	logic             wa;
	logic             wb;
	logic             ra;
	logic             rb;
	logic             wcnt;
	logic             wctl;
	logic             wacc;
	logic             racc;
	logic             busy;
	logic             macf;
	logic             clear;
	logic             go;
	mac40_op_t        go_op;
	logic             err;
	logic             load_a;
	logic             load_b;
	logic             rd_done;
	logic             eng_done;
	logic [31:0]      eng_res;
	logic [15:0]      eng_rem;
	logic [4:0]       eng_exp;
	function automatic logic [2:0] ptr_next(input logic [2:0] p);
		return (p == 3'(ACC_BYTES - 1)) ? 3'd0 : 3'(p + 3'd1);
	endfunction

	mac40_ahb u_ahb (
		.mclk      (mclk),
		.rst_b     (rst_b),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hready    (hready),
		.hwdata    (hwdata),
		.hreadyout (hreadyout),
		.hrdata    (hrdata),
		.hresp     (hresp),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_idx   (reg_idx),
		.reg_wdata (reg_wdata),
		.reg_rdata (reg_rdata)
	);
	mac40_engine u_eng (
		.mclk  (mclk),
		.rst_b (rst_b),
		.start (go),
		.abort (clear),
		.op    (go_op),
		.opa   (load_a ? {opa_q[31:16], reg_wdata, opa_q[7:0]} : opa_q), // last byte in flight
		.opb   (load_b ? {reg_wdata, opb_q[7:0]} : opb_q),
		.cnt   (reg_wdata[4:0]),
		.dir   (reg_wdata[CNT_DIR_BIT]),
		.done  (eng_done),
		.res   (eng_res),
		.rem   (eng_rem),
		.expo  (eng_exp)
	);

	// hsize is accepted but every register is one byte in a word
	always_comb
	begin
		wa   = 1'b0;
		wb   = 1'b0;
		ra   = 1'b0;
		rb   = 1'b0;
		wcnt = 1'b0;
		wctl = 1'b0;
		wacc = 1'b0;
		racc = 1'b0;
		if (reg_idx == IDX_A)
		begin
			wa = reg_wr;
			ra = reg_rd;
		end
		else if (reg_idx == IDX_B)
		begin
			wb = reg_wr;
			rb = reg_rd;
		end
		else if (reg_idx == IDX_CNT)
			wcnt = reg_wr;
		else if (reg_idx == IDX_CTL)
			wctl = reg_wr;
		else if (reg_idx == IDX_ACC)
		begin
			wacc = reg_wr;
			racc = reg_rd;
		end
	end

	assign busy  = (seq_q == SQ_RUN) || (seq_q == SQ_ERR);
	assign macf  = (seq_q == SQ_RUN);
	assign clear = wctl && !reg_wdata[CTL_BUSY_BIT] && busy;

	// sequence decoding: the order of accesses selects the operation; the count value picks shift or normalize
	always_comb
	begin
		go      = 1'b0;
		go_op   = OP_DIV32;
		err     = 1'b0;
		load_a  = 1'b0;
		load_b  = 1'b0;
		rd_done = 1'b0;
		case (seq_q)
			SQ_IDLE, SQ_LOAD:
			begin
				if (wa)
				begin
					if (b_cnt_q == 2'd0 && a_cnt_q != A_BYTES_32)
						load_a = 1'b1;
					else if (b_cnt_q == B_BYTES && a_cnt_q < A_BYTES_16)
					begin
						load_a = 1'b1;
						go     = (a_cnt_q == 3'd1);
						go_op  = OP_MUL;
					end
					else
						err = 1'b1;
				end
				else if (wb)
				begin
					if (b_cnt_q == B_BYTES)
						err = 1'b1;
					else if (a_cnt_q == 3'd0)
						load_b = 1'b1;
					else if (a_cnt_q == A_BYTES_16 || a_cnt_q == A_BYTES_32)
					begin
						load_b = 1'b1;
						go     = (b_cnt_q == 2'd1);
						go_op  = (a_cnt_q == A_BYTES_32) ? OP_DIV32 : OP_DIV16;
					end
					else
						err = 1'b1;
				end
				else if (wcnt && a_cnt_q == A_BYTES_32 && b_cnt_q == 2'd0)
				begin
					go    = 1'b1;
					go_op = (reg_wdata[4:0] == 5'h00) ? OP_NORM : OP_SHIFT;
				end
				else if ((ra || rb) && seq_q == SQ_LOAD)
					err = 1'b1;
			end
			SQ_RUN:
				err = wa || wb || ra || rb || wacc || racc;
			SQ_READ:
			begin
				if (wa || wb)
					err = 1'b1;
				else if (ra)
				begin
					if (ard_q == 3'd4)
						err = 1'b1;
					else
						rd_done = (ard_q == 3'd3) && (op_q != OP_DIV32)
							&& (op_q != OP_DIV16);
				end
				else if (rb)
				begin
					if (ard_q != 3'd4 || (op_q != OP_DIV32 && op_q != OP_DIV16))
						err = 1'b1;
					else
						rd_done = (brd_q == 2'd1);
				end
			end
			default:
				err = 1'b0;
		endcase
	end

	// sequence state; bus accesses and engine done move it
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			seq_q <= SQ_IDLE;
		else if (clear)
			seq_q <= SQ_IDLE;
		else if (err)
			seq_q <= SQ_ERR;
		else if (go)
			seq_q <= SQ_RUN;
		else if (load_a || load_b)
			seq_q <= SQ_LOAD;
		else if (seq_q == SQ_RUN && eng_done)
			seq_q <= SQ_READ;
		else if (rd_done)
			seq_q <= SQ_IDLE;
	end

	// operand byte counters and read pointers
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			a_cnt_q <= 3'd0;
			b_cnt_q <= 2'd0;
			ard_q   <= 3'd0;
			brd_q   <= 2'd0;
			op_q    <= OP_DIV32;
		end
		else if (clear || err || go)
		begin
			a_cnt_q <= 3'd0;
			b_cnt_q <= 2'd0;
			ard_q   <= 3'd0;
			brd_q   <= 2'd0;
			if (go)
				op_q <= go_op;
		end
		else
		begin
			if (load_a)
				a_cnt_q <= a_cnt_q + 3'd1;
			if (load_b)
				b_cnt_q <= b_cnt_q + 2'd1;
			if (seq_q == SQ_READ && ra)
				ard_q <= ard_q + 3'd1;
			if (seq_q == SQ_READ && rb)
				brd_q <= brd_q + 2'd1;
		end
	end

	// operand storage; multiplicand bytes share the low A bytes
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			opa_q <= 32'h0000_0000;
			opb_q <= 16'h0000;
		end
		else
		begin
			if (load_a)
				opa_q[{a_cnt_q[1:0], 3'b000} +: 8] <= reg_wdata;
			if (load_b)
				opb_q[{b_cnt_q[0], 3'b000} +: 8] <= reg_wdata;
		end
	end

	// count register; normalize writes the exponent back here
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_q <= CNT_RST;
			dir_q <= DIR_RST;
		end
		else if (seq_q == SQ_RUN && eng_done && op_q == OP_NORM)
			cnt_q <= eng_exp;
		else if (wcnt && seq_q != SQ_RUN)
		begin
			cnt_q <= reg_wdata[CNT_W-1:0];
			dir_q <= reg_wdata[CNT_DIR_BIT];
		end
	end

	// results and accumulator: captured on completion, no extra latency
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			res_q    <= 32'h0000_0000;
			rem_q    <= 16'h0000;
			acc_q    <= '0;
			acc_wp_q <= 3'd0;
			acc_rp_q <= 3'd0;
		end
		else if (seq_q == SQ_RUN)
		begin
			if (eng_done)
			begin
				res_q <= eng_res;
				rem_q <= eng_rem;
			end
			if (eng_done && op_q != OP_SHIFT && op_q != OP_NORM)
				acc_q <= acc_q + ACC_W'(eng_res);
		end
		else if (wacc)
		begin
			acc_q[8 * acc_wp_q +: 8] <= reg_wdata;
			acc_wp_q <= ptr_next(acc_wp_q);
		end
		else if (racc)
			acc_rp_q <= ptr_next(acc_rp_q);
	end

	// read data; unmapped indexes read zero
	always_comb
	begin
		reg_rdata = 8'h00;
		if (reg_idx == IDX_A)
			reg_rdata = res_q[{~ard_q[1:0], 3'b000} +: 8];
		else if (reg_idx == IDX_B)
			reg_rdata = rem_q[{~brd_q[0], 3'b000} +: 8];
		else if (reg_idx == IDX_CNT)
			reg_rdata = {2'b00, dir_q, cnt_q};
		else if (reg_idx == IDX_CTL)
		begin
			reg_rdata[CTL_BUSY_BIT] = busy;
			reg_rdata[CTL_MACF_BIT] = macf;
		end
		else if (reg_idx == IDX_ACC)
			reg_rdata = acc_q[8 * (ACC_BYTES - 1 - int'(acc_rp_q)) +: 8];
	end
endmodule

// File: pkg/mac40_pkg.sv
// shared constants and types of the 40-bit math accelerator
package mac40_pkg;
	// register indexes; byte address is four times the index
	localparam logic [7:0] IDX_CNT = 8'hD1;
	localparam logic [7:0] IDX_CTL = 8'hD2;
	localparam logic [7:0] IDX_A   = 8'hD3;
	localparam logic [7:0] IDX_B   = 8'hD4;
	localparam logic [7:0] IDX_ACC = 8'hD5;

	// control/status and count field positions
	localparam int CTL_BUSY_BIT = 7;
	localparam int CTL_MACF_BIT = 6;
	localparam int CNT_DIR_BIT  = 5;
	localparam int CNT_W        = 5;
	localparam logic [4:0] CNT_RST = 5'h00;
	localparam logic       DIR_RST = 1'b0;

	// execution times in clock periods
	localparam logic [5:0] LAT_DIV32 = 6'd36;
	localparam logic [5:0] LAT_DIV16 = 6'd24;
	localparam logic [5:0] LAT_MUL   = 6'd24;
	localparam logic [5:0] LAT_SHIFT = 6'd36;
	localparam logic [5:0] LAT_NORM  = 6'd36;
	localparam logic [5:0] STEPS_DIV32 = 6'd32;
	localparam logic [5:0] STEPS_DIV16 = 6'd16;

	// operand byte counts
	localparam logic [2:0] A_BYTES_32 = 3'd4;
	localparam logic [2:0] A_BYTES_16 = 3'd2;
	localparam logic [1:0] B_BYTES    = 2'd2;

	typedef enum logic [2:0] {
		OP_DIV32 = 3'b000,
		OP_DIV16 = 3'b001,
		OP_MUL   = 3'b010,
		OP_SHIFT = 3'b011,
		OP_NORM  = 3'b100
	} mac40_op_t;

	typedef enum logic [2:0] {
		SQ_IDLE = 3'b000,
		SQ_LOAD = 3'b001,
		SQ_RUN  = 3'b010,
		SQ_READ = 3'b011,
		SQ_ERR  = 3'b100
	} mac40_seq_t;
endpackage

// File: hdl/mac40_ahb.sv
// AHB-Lite slave front end with one wait state per transfer
`timescale 1ns/10ps
module mac40_ahb
	import mac40_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic [7:0]       reg_idx,
	output logic [7:0]       reg_wdata,
	input  wire logic [7:0]  reg_rdata
);
	logic dp_q;
	logic wr_q;
	logic ok_q;

	// the wait state lets read data and read side effects come from flops
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dp_q      <= 1'b0;
			wr_q      <= 1'b0;
			ok_q      <= 1'b0;
			reg_idx   <= 8'h00;
			hreadyout <= 1'b1;
			hrdata    <= 32'h0000_0000;
			hresp     <= 1'b0;
		end
		else if (dp_q)
		begin
			dp_q      <= 1'b0;
			hreadyout <= 1'b1;
			if (!wr_q)
				hrdata <= ok_q ? {24'h00_0000, reg_rdata} : 32'h0000_0000;
		end
		else if (hsel && htrans[1] && hready)
		begin
			dp_q      <= 1'b1;
			wr_q      <= hwrite;
			ok_q      <= (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'b00);
			reg_idx   <= haddr[9:2];
			hreadyout <= 1'b0;
		end
	end

	assign reg_wr    = dp_q && wr_q && ok_q;
	assign reg_rd    = dp_q && !wr_q && ok_q;
	assign reg_wdata = hwdata[7:0];
endmodule

// File: hdl/mac40_engine.sv
// arithmetic engine: iterative divide, multiply, shift, normalize
`timescale 1ns/10ps
module mac40_engine
	import mac40_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst_b,
	input  wire logic       start,
	input  wire logic       abort,
	input  mac40_pkg::mac40_op_t op,
	input  wire logic [31:0] opa,
	input  wire logic [15:0] opb,
	input  wire logic [4:0]  cnt,
	input  wire logic        dir,
	output logic             done,
	output logic [31:0]      res,
	output logic [15:0]      rem,
	output logic [4:0]       expo
);
	logic [5:0]  lat_q;
	logic [5:0]  steps_q;
	logic        run_q;
	logic [31:0] w_q;
	logic [15:0] r_q;
	logic [15:0] dv_q;
	logic [4:0]  e_q;
	logic [16:0] trial;
	logic        ge;

	function automatic logic [4:0] lead_zeros(input logic [31:0] v);
		logic [4:0] n;
		n = 5'd0;
		for (int i = 0; i < 32; i++)
			if (v[i])
				n = 5'(31 - i);
		return n;
	endfunction

	// restoring division, one quotient bit per clock
	assign trial = {r_q, w_q[31]};
	assign ge    = trial >= {1'b0, dv_q};

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			run_q <= 1'b0;
			done  <= 1'b0;
			lat_q <= 6'd0;
			steps_q <= 6'd0;
			w_q   <= 32'h0000_0000;
			r_q   <= 16'h0000;
			dv_q  <= 16'h0000;
			e_q   <= 5'h00;
		end
		else if (abort)
		begin
			run_q <= 1'b0;
			done  <= 1'b0;
		end
		else if (start)
		begin
			run_q <= 1'b1;
			done  <= 1'b0;
			r_q   <= 16'h0000;
			dv_q  <= opb;
			steps_q <= 6'd0;
			case (op)
				OP_DIV32:
				begin
					w_q <= opa;
					steps_q <= STEPS_DIV32;
					lat_q <= LAT_DIV32 - 6'd1;
				end
				OP_DIV16:
				begin
					w_q <= {opa[15:0], 16'h0000};
					steps_q <= STEPS_DIV16;
					lat_q <= LAT_DIV16 - 6'd1;
				end
				OP_MUL:
				begin
					w_q <= {16'h0000, opa[15:0]} * {16'h0000, opb};
					lat_q <= LAT_MUL - 6'd1;
				end
				OP_SHIFT:
				begin
					w_q <= dir ? (opa >> cnt) : (opa << cnt);
					lat_q <= LAT_SHIFT - 6'd1;
				end
				default:
				begin
					w_q <= opa << lead_zeros(opa);
					e_q <= lead_zeros(opa);
					lat_q <= LAT_NORM - 6'd1;
				end
			endcase
		end
		else if (run_q)
		begin
			if (steps_q != 6'd0)
			begin
				r_q <= ge ? 16'(trial - {1'b0, dv_q}) : trial[15:0];
				w_q <= {w_q[30:0], ge};
				steps_q <= steps_q - 6'd1;
			end
			lat_q <= lat_q - 6'd1;
			if (lat_q == 6'd0)
			begin
				run_q <= 1'b0;
				done  <= 1'b1;
			end
		end
		else
			done <= 1'b0;
	end

	assign res  = w_q;
	assign rem  = r_q;
	assign expo = e_q;
endmodule

// File: verif/mac40_master.sv
// bus master standing in for the processor core
`timescale 1ns/10ps
module mac40_master
(
	input  wire logic        mclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata,
	output logic             stuck
);
	initial
	begin
		hsel   = 1'b0;
		haddr  = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize  = 3'h2;
		hwdata = 32'h0;
		stuck  = 1'b0;
	end

	// one word; read data taken at the completing edge
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
		output logic [7:0] rd);
		int n;
		n = 0;
		hsel   <= 1'b1;
		haddr  <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (hready !== 1'b1 && n < 20);
		htrans <= 2'h0;
		// idle data lanes toggle so stale data never looks valid
		hwdata <= w ? {24'h0, wd} : ~hwdata;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (hready !== 1'b1 && n < 20);
		rd = hrdata[7:0];
		if (n >= 20)
			stuck <= 1'b1;
	endtask
endmodule

// File: verif/mac40_properties.sv
// bus level properties of the math accelerator
`timescale 1ns/10ps
module mac40_properties
	import mac40_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst_b,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        hresp
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	logic rd_dp_q;
	logic ctl_wr_q;
	logic clr_q;
	wire logic taken = hsel & htrans[1] & hready;
	wire logic bad = haddr[31:10] != 22'h0 || haddr[1:0] != 2'h0 ||
		haddr[9:2] < IDX_CNT || haddr[9:2] > IDX_ACC;
	wire logic hit_ctl = !bad && haddr[9:2] == IDX_CTL;

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rd_dp_q  <= 1'b0;
			ctl_wr_q <= 1'b0;
		end
		else
		begin
			rd_dp_q  <= taken & ~hwrite;
			ctl_wr_q <= taken & hwrite & hit_ctl;
		end
	end

	// any other mapped access may start or break a sequence, so forget the clear
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			clr_q <= 1'b1;
		else if (taken && !bad && !hit_ctl)
			clr_q <= 1'b0;
		else if (ctl_wr_q && !hwdata[CTL_BUSY_BIT])
			clr_q <= 1'b1;
	end

	okay_resp_a: assert property (hresp == 1'b0)
		else $error("slave gave a non okay response");
	one_wait_a: assert property (taken |=> !hreadyout ##1 hreadyout)
		else $error("transfer did not take exactly one wait state");
	idle_ready_a: assert property (!taken |=> hreadyout)
		else $error("wait state without a transfer");
	rdata_upper_a: assert property (hrdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	rdata_hold_a: assert property (!rd_dp_q |=> $stable(hrdata))
		else $error("read data changed outside a read");
	unmapped_zero_a: assert property (taken && !hwrite && bad |-> ##2 hrdata == 32'h0)
		else $error("unmapped read did not return zero");
	ctl_spare_a: assert property (taken && !hwrite && hit_ctl |-> ##2 hrdata[5:0] == 6'h0)
		else $error("spare status bits not zero");
	clear_idle_a: assert property (taken && !hwrite && hit_ctl && clr_q |-> ##2
		hrdata[7:6] == 2'b00)
		else $error("busy still set after software clear");

	cover property (taken && hwrite && haddr[9:2] == IDX_ACC);
	cover property (taken && !hwrite && bad);
	cover property (ctl_wr_q && !hwdata[CTL_BUSY_BIT]);
endmodule

bind mac40_top mac40_properties u_props (.mclk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hwdata, .hreadyout, .hrdata, .hresp);

// File: verif/tb_math_accelerator_mac40.sv
// self-checking bench for the math accelerator
`timescale 1ns/10ps
module tb_math_accelerator_mac40;
	import mac40_pkg::*;
	logic        mclk;
	logic        rst_b;
	logic        hsel, hwrite, hready, hresp, stuck;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, x;
	logic [39:0] v, acc;
	logic [15:0] a, d;
	logic [7:0]  b;
	int          err_total, checked, cyc;

	mac40_master bus (.mclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .stuck);
	mac40_top DUT (.mclk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
		.hwdata, .hreadyout(hready), .hrdata, .hresp);

	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (stuck)
		begin
			err_total++;
			end_of_test;
		end
	end

	task automatic end_of_test;
		if (err_total == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
		logic [7:0] y;
		bus.xfer(1'b1, idx, dat, y);
	endtask

	task automatic rd(input logic [7:0] idx, output logic [7:0] dat);
		bus.xfer(1'b0, idx, 8'h00, dat);
	endtask

	// bytes go least significant first
	task automatic wr_n(input logic [7:0] idx, input logic [39:0] val, input int n);
		for (int i = 0; i < n; i++)
			wr(idx, val[8*i +: 8]);
	endtask

	// bytes come most significant first
	task automatic rd_n(input logic [7:0] idx, input int n, output logic [39:0] val);
		logic [7:0] y;
		val = 40'h0;
		for (int i = 0; i < n; i++)
		begin
			rd(idx, y);
			val = {val[31:0], y};
		end
	endtask

	// poll busy; slack covers the three-cycle poll granularity
	task automatic run(input logic [5:0] lat);
		logic [7:0] s;
		int t0;
		t0 = cyc;
		rd(IDX_CTL, s);
		chk("busy after start", s[CTL_BUSY_BIT], 1'b1);
		for (int i = 0; i < 40 && s[CTL_BUSY_BIT] === 1'b1; i++)
			rd(IDX_CTL, s);
		chk("busy at end", s[CTL_BUSY_BIT], 1'b0);
		chk("run time", cyc - t0 >= lat && cyc - t0 <= lat + 8, 1'b1);
	endtask

	initial
	begin
		err_total = 0;
		checked = 0;
		cyc = 0;
		rst_b = 1'b0;
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		rd(IDX_CTL, b);
		chk("status reset", b, 8'h00);
		rd_n(IDX_ACC, 5, v);
		chk("acc reset", v, 40'h0);
		acc = 40'hFF_FFFF_FF00;
		wr_n(IDX_ACC, acc, 5);
		rd_n(IDX_ACC, 5, v);
		chk("acc load", v, acc);
		wr(IDX_A, 8'h11);
		rd(IDX_B, b);
		rd(IDX_CTL, b);
		chk("busy on error", b[CTL_BUSY_BIT], 1'b1);
		wr(IDX_CTL, 8'h00);
		rd(IDX_CTL, b);
		chk("busy cleared", b, 8'h00);
		a = 16'hFEDC;
		d = 16'hBA98;
		wr_n(IDX_B, {24'h0, d}, 2);
		rd(8'hD0, b);
		chk("unmapped read", b, 8'h00);
		wr(8'hD7, 8'h5A);
		wr_n(IDX_A, {24'h0, a}, 2);
		run(LAT_MUL);
		rd_n(IDX_A, 4, v);
		chk("product", v, {24'h0, a} * {24'h0, d});
		acc = acc + {24'h0, a} * {24'h0, d};
		x = 32'h8765_4321;
		d = 16'h0123;
		wr_n(IDX_A, {8'h0, x}, 4);
		wr_n(IDX_B, {24'h0, d}, 2);
		run(LAT_DIV32);
		rd_n(IDX_A, 4, v);
		chk("quotient 32", v, {8'h0, x / d});
		acc = acc + {8'h0, x / d};
		rd_n(IDX_B, 2, v);
		chk("remainder 32", v, {8'h0, x % d});
		a = 16'hF00D;
		d = 16'h0007;
		wr_n(IDX_A, {24'h0, a}, 2);
		wr_n(IDX_B, {24'h0, d}, 2);
		run(LAT_DIV16);
		rd_n(IDX_A, 4, v);
		chk("quotient 16", v, {24'h0, a / d});
		acc = acc + {24'h0, a / d};
		rd_n(IDX_B, 2, v);
		chk("remainder 16", v, {24'h0, a % d});
		rd_n(IDX_ACC, 5, v);
		chk("acc sum", v, acc);
		x = 32'h8000_0F01;
		for (int dir = 0; dir < 2; dir++)
		begin
			wr_n(IDX_A, {8'h0, x}, 4);
			wr(IDX_CNT, dir ? 8'h29 : 8'h04);
			run(LAT_SHIFT);
			rd_n(IDX_A, 4, v);
			chk("shift", v, {8'h0, dir ? x >> 9 : x << 4});
		end
		x = 32'h0003_1234;
		wr_n(IDX_A, {8'h0, x}, 4);
		wr(IDX_CNT, 8'h00);
		run(LAT_NORM);
		rd_n(IDX_A, 4, v);
		chk("mantissa", v, {8'h0, x << 14});
		rd(IDX_CNT, b);
		chk("exponent", b, 8'h0E);
		rd_n(IDX_ACC, 5, v);
		chk("acc untouched", v, acc);
		end_of_test;
	end
endmodule
